//--- rtl/queue_ptr_regs.sv
/*
 * Queue pointer register bank: base, size, disable and five pointers.
 * Assumes a one-cycle register port from a local host on the same clock.
 */
`include "queue_ptr_defs.svh"

module queue_ptr_regs (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_srst,
	// Register port
	input  wire logic [11:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// Device queue events
	input  wire logic        i_in_free_take,
	input  wire logic        i_in_post_add,
	input  wire logic        i_out_free_return,
	// Entry addresses and queue disable
	output logic      [31:0] o_in_free_addr,
	output logic      [31:0] o_in_post_addr,
	output logic      [31:0] o_out_free_addr,
	output logic             o_queue_port_disable
);

	typedef struct packed {
		queue_ptr_pkg::base_t base;
		queue_ptr_pkg::size_t size;
		logic                 dis;
		queue_ptr_pkg::ofs_t  in_post_bot;
		queue_ptr_pkg::ofs_t  out_free_bot;
		logic [31:0]          rdata;
		logic [31:0]          a_in_free;
		logic [31:0]          a_in_post;
		logic [31:0]          a_out_free;
	} regs_s;

	regs_s state_q;
	regs_s state_d;
	queue_ptr_pkg::ofs_t in_free_bot;
	queue_ptr_pkg::ofs_t in_post_top;
	queue_ptr_pkg::ofs_t out_free_top;
	logic ld_ifb;
	logic ld_ipt;
	logic ld_oft;
	logic wr_ok;

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	// pointer writes blocked while disabled
	assign wr_ok  = i_wr && !state_q.dis;
	assign ld_ifb = wr_ok && (i_addr == `QP_OFF_IN_FREE_BOT);
	assign ld_ipt = wr_ok && (i_addr == `QP_OFF_IN_POST_TOP);
	assign ld_oft = wr_ok && (i_addr == `QP_OFF_OUT_FREE_TOP);

	// ------------------------------------------------------------
	// Device-maintained pointers
	// ------------------------------------------------------------
	// inbound free bottom
	queue_ptr_step u_in_free_bot (
		.i_ref_clk  (i_ref_clk),
		.i_srst     (i_srst),
		.i_load     (ld_ifb),
		.i_load_ofs (i_wdata[`QP_OFS_MSB:`QP_OFS_LSB]),
		.i_adv      (i_in_free_take),
		.i_size     (state_q.size),
		.o_ofs      (in_free_bot)
	);
	queue_ptr_step u_in_post_top (
		.i_ref_clk  (i_ref_clk),
		.i_srst     (i_srst),
		.i_load     (ld_ipt),
		.i_load_ofs (i_wdata[`QP_OFS_MSB:`QP_OFS_LSB]),
		.i_adv      (i_in_post_add),
		.i_size     (state_q.size),
		.o_ofs      (in_post_top)
	);
	queue_ptr_step u_out_free_top (
		.i_ref_clk  (i_ref_clk),
		.i_srst     (i_srst),
		.i_load     (ld_oft),
		.i_load_ofs (i_wdata[`QP_OFS_MSB:`QP_OFS_LSB]),
		.i_adv      (i_out_free_return),
		.i_size     (state_q.size),
		.o_ofs      (out_free_top)
	);

	// ------------------------------------------------------------
	// Register state, read data and entry addresses
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		// Control register writes are always allowed
		// megabyte-aligned base field
		if (i_wr && i_addr == `QP_OFF_CTRL) begin
			state_d.base = i_wdata[`QP_BASE_MSB:`QP_BASE_LSB];
			state_d.size = i_wdata[`QP_SIZE_MSB:`QP_SIZE_LSB];
			state_d.dis  = i_wdata[`QP_DIS_BIT];
		end
		if (wr_ok && i_addr == `QP_OFF_IN_POST_BOT) begin
			state_d.in_post_bot = i_wdata[`QP_OFS_MSB:`QP_OFS_LSB];
		end
		if (wr_ok && i_addr == `QP_OFF_OUT_FREE_BOT) begin
			state_d.out_free_bot = i_wdata[`QP_OFS_MSB:`QP_OFS_LSB];
		end
		// base shows above every pointer offset; pointer low bits zero
		state_d.rdata = 32'h0000_0000;
		if (i_rd) begin
			case (i_addr)
				`QP_OFF_CTRL: state_d.rdata = {state_q.base, 16'h0000,
					state_q.dis, state_q.size};
				`QP_OFF_IN_FREE_BOT:  state_d.rdata = {state_q.base, in_free_bot, 2'b00};
				`QP_OFF_IN_POST_TOP:  state_d.rdata = {state_q.base, in_post_top, 2'b00};
				`QP_OFF_IN_POST_BOT:  state_d.rdata = {state_q.base, state_q.in_post_bot, 2'b00};
				`QP_OFF_OUT_FREE_TOP: state_d.rdata = {state_q.base, out_free_top, 2'b00};
				`QP_OFF_OUT_FREE_BOT: state_d.rdata = {state_q.base, state_q.out_free_bot, 2'b00};
				default:              state_d.rdata = 32'h0000_0000;
			endcase
			// pointer reads return all ones while disabled
			if (state_q.dis && i_addr != `QP_OFF_CTRL) begin
				state_d.rdata = `QP_ALL_ONES;
			end
		end
		// entry address joins base, offset and two zeros
		state_d.a_in_free  = {state_d.base, in_free_bot, 2'b00};
		state_d.a_in_post  = {state_d.base, in_post_top, 2'b00};
		state_d.a_out_free = {state_d.base, out_free_top, 2'b00};
		if (i_srst) begin
			state_d = '0;
		end
	end

	// State register
	always_ff @(posedge i_ref_clk) begin
		state_q <= state_d;
	end

	// Outputs straight from the state register
	assign o_rdata              = state_q.rdata;
	assign o_in_free_addr       = state_q.a_in_free;
	assign o_in_post_addr       = state_q.a_in_post;
	assign o_out_free_addr      = state_q.a_out_free;
	assign o_queue_port_disable = state_q.dis;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence rd_ptr_s;
		i_rd && !state_q.dis && (i_addr == `QP_OFF_IN_POST_BOT);
	endsequence

	// Inbound post advance, well inside the largest queue
	sequence post_adv_s;
		i_in_post_add && !ld_ipt && state_q.size == `QP_SIZE_64K && in_post_top < 18'h0_ffff;
	endsequence
	// Outbound free advance, well inside the largest queue
	sequence out_adv_s;
		i_out_free_return && !ld_oft && state_q.size == `QP_SIZE_64K && out_free_top < 18'h0_ffff;
	endsequence

	base_readback_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		rd_ptr_s |=> (o_rdata[31:20] == $past(state_q.base)))
		else $error("base field missing on pointer read");
	low_bits_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(i_rd && !state_q.dis && i_addr != `QP_OFF_CTRL) |=> (o_rdata[1:0] == 2'b00))
		else $error("pointer low bits not zero");
	disabled_read_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(i_rd && state_q.dis && i_addr == `QP_OFF_IN_FREE_BOT) |=> (o_rdata == `QP_ALL_ONES))
		else $error("disabled read not all ones");
	disabled_write_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(i_wr && state_q.dis && i_addr == `QP_OFF_IN_POST_BOT)
		|=> $stable(state_q.in_post_bot))
		else $error("write landed while disabled");
	host_store_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(wr_ok && i_addr == `QP_OFF_IN_POST_BOT)
		|=> (state_q.in_post_bot == $past(i_wdata[19:2])))
		else $error("host bottom pointer not stored");
	host_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!(i_wr && i_addr == `QP_OFF_OUT_FREE_BOT) |=> $stable(state_q.out_free_bot))
		else $error("host bottom pointer moved by itself");
	// Device pointers step one word inside the largest queue
	advance_four_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(i_in_free_take && !ld_ifb && state_q.size == `QP_SIZE_64K && in_free_bot < 18'h0_ffff)
		|=> (in_free_bot == $past(in_free_bot) + 18'h0_0001))
		else $error("inbound free bottom did not step by four");
	post_top_step_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		post_adv_s |=> (in_post_top == $past(in_post_top) + 18'h0_0001))
		else $error("inbound post top did not step by four");
	out_free_step_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		out_adv_s |=> (out_free_top == $past(out_free_top) + 18'h0_0001))
		else $error("outbound free top did not step by four");

	// Entry addresses trail the pointers by one register
	entry_addr_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		1'b1 |=> (o_in_post_addr == {state_q.base, $past(in_post_top), 2'b00}))
		else $error("entry address mismatch");
	entry_free_addr_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		1'b1 |=> (o_in_free_addr == {state_q.base, $past(in_free_bot), 2'b00}))
		else $error("inbound free entry address mismatch");
	entry_out_addr_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		1'b1 |=> (o_out_free_addr == {state_q.base, $past(out_free_top), 2'b00}))
		else $error("outbound free entry address mismatch");

	// Control register store and refused pointer loads
	ctrl_store_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(i_wr && i_addr == `QP_OFF_CTRL)
		|=> (state_q.base == $past(i_wdata[31:20]) && state_q.size == $past(i_wdata[2:0])))
		else $error("control write not stored");
	disabled_load_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(i_wr && state_q.dis && i_addr == `QP_OFF_IN_FREE_BOT && !i_in_free_take)
		|=> $stable(in_free_bot))
		else $error("pointer loaded while disabled");

	// Reset leaves every field at zero
	reset_clear_a: assert property (@(posedge i_ref_clk)
		i_srst |=> (state_q == '0 && in_free_bot == 18'h0_0000
			&& in_post_top == 18'h0_0000 && out_free_top == 18'h0_0000))
		else $error("state not cleared by reset");

endmodule // queue_ptr_regs

//--- rtl/queue_ptr_defs.svh
/*
 * Offsets, field positions, reset values and size codes for the queue
 * pointer register bank. Assumes a 32-bit register port, byte offsets.
 */
// What this block does
// - Pointer bits 31:20 read base, writes ignored
// - Inbound free bottom, device advances it
// - Inbound post top, device advances it
// - Outbound free top, device advances it
// - Step four bytes, wrap at size
// - Entry address is base, offset, 00
// - Size code sets entries, others reserved
// - Base aligned to one megabyte
// - Queue disable: ignore pointer writes, pointers read ones
`ifndef QUEUE_PTR_DEFS_SVH
`define QUEUE_PTR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define QP_OFF_CTRL      12'h0_200
`define QP_OFF_IN_FREE_BOT 12'h0_208
`define QP_OFF_IN_POST_TOP 12'h0_20c
`define QP_OFF_IN_POST_BOT 12'h0_210
`define QP_OFF_OUT_FREE_TOP 12'h0_214
`define QP_OFF_OUT_FREE_BOT 12'h0_218

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define QP_BASE_MSB      31
`define QP_BASE_LSB      20
`define QP_OFS_MSB       19
`define QP_OFS_LSB       2
`define QP_SIZE_MSB      2
`define QP_SIZE_LSB      0
`define QP_DIS_BIT       3
`define QP_RST_BASE      12'h0_000
`define QP_RST_OFS       18'h0_0000
`define QP_RST_SIZE      3'h0
`define QP_STEP          18'h0_0001
`define QP_ALL_ONES      32'hffff_ffff
`define QP_SIZE_256      3'h0
`define QP_SIZE_1K       3'h1
`define QP_SIZE_4K       3'h2
`define QP_SIZE_16K      3'h3
`define QP_SIZE_64K      3'h4

`endif

//--- rtl/queue_ptr_pkg.sv
/*
 * Types for the queue pointer register bank.
 * Assumes queue_ptr_defs.svh for the numbers.
 */
package queue_ptr_pkg;

	// Word offset of a queue entry within one queue
	typedef logic [17:0] ofs_t;
	// Queue base address, one megabyte granule
	typedef logic [11:0] base_t;
	// Queue size code
	typedef logic [2:0]  size_t;

endpackage : queue_ptr_pkg

//--- rtl/queue_ptr_step.sv
/*
 * One device-maintained queue pointer: host load, advance by one entry
 * with wrap at the queue size. Assumes a single clock, synchronous reset.
 */
`include "queue_ptr_defs.svh"

module queue_ptr_step (
	// Clock and reset
	input  wire logic                i_ref_clk,
	input  wire logic                i_srst,
	// Host load
	input  wire logic                i_load,
	input  wire queue_ptr_pkg::ofs_t i_load_ofs,
	// Device advance
	input  wire logic                i_adv,
	input  wire queue_ptr_pkg::size_t i_size,
	// Pointer
	output logic [17:0]              o_ofs
);

	typedef struct packed {
		logic [17:0] ofs;
	} step_s;

	step_s state_q;
	step_s state_d;
	logic [17:0] mask;
	logic [17:0] inc;

	// Word-count mask of the selected queue size
	// size code mask
	always_comb begin
		case (i_size)
			`QP_SIZE_256: mask = 18'h0_00ff;
			`QP_SIZE_1K:  mask = 18'h0_03ff;
			`QP_SIZE_4K:  mask = 18'h0_0fff;
			`QP_SIZE_16K: mask = 18'h0_3fff;
			default:      mask = 18'h0_ffff;
		endcase
	end

	// Next pointer value
	always_comb begin
		state_d = state_q;
		inc     = state_q.ofs + `QP_STEP;
		if (i_srst) begin
			state_d.ofs = `QP_RST_OFS;
		end else if (i_load) begin
			state_d.ofs = i_load_ofs;
		end else if (i_adv) begin
			state_d.ofs = (state_q.ofs & ~mask) | (inc & mask);
		end
	end

	// State register
	always_ff @(posedge i_ref_clk) begin
		state_q <= state_d;
	end

	assign o_ofs = state_q.ofs;

	// Wrap stays inside one queue
	wrap_in_queue_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(i_adv && !i_load) |=> ((o_ofs & ~$past(mask)) == ($past(o_ofs) & ~$past(mask))))
		else $error("pointer left its queue on advance");

endmodule // queue_ptr_step

//--- tb/queue_host_model.sv
/*
 * Host model: register port master for the queue pointer bank.
 * Assumes one clock shared with the bank; strobes taken on rising edges.
 */
module queue_host_model (
	// Clock
	input  wire logic        i_ref_clk,
	// Register port
	output logic      [11:0] o_addr,
	output logic      [31:0] o_wdata,
	output logic             o_wr,
	output logic             o_rd,
	input  wire logic [31:0] i_rdata
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus at time zero
	initial begin
		o_addr  = 12'h000;
		o_wdata = 32'h0000_0000;
		o_wr    = 1'b0;
		o_rd    = 1'b0;
	end

	// host loads pointers
	// One-cycle write; idle lines show inverted data afterwards
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		o_wr    <= 1'b1;
		o_addr  <= a;
		o_wdata <= d;
		@(posedge i_ref_clk);
		o_wr    <= 1'b0;
		o_addr  <= ~a;
		o_wdata <= ~d;
	endtask

	// One-cycle read; data sampled in the following cycle only
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge i_ref_clk);
		o_rd   <= 1'b1;
		o_addr <= a;
		@(posedge i_ref_clk);
		o_rd   <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
	endtask
endmodule // queue_host_model

//--- tb/tb.sv
/*
 * Self-checking bench for the queue pointer register bank.
 * Assumes the host model drives the register port on the same clock.
 */
`include "queue_ptr_defs.svh"

module tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [11:0] BASE = 12'habc;

	logic        ref_clk = 1'b0;
	logic        srst    = 1'b1;
	logic [2:0]  ev      = 3'h0;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] a_out [3];
	logic        wr;
	logic        rd;
	logic        dis;
	int          n_fail  = 0;
	int          checks  = 0;

	// Clock
	always #2 ref_clk = ~ref_clk;

	queue_host_model u_host (.i_ref_clk(ref_clk), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd), .i_rdata(rdata));

	queue_ptr_regs u_dut (.i_ref_clk(ref_clk), .i_srst(srst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_in_free_take(ev[0]), .i_in_post_add(ev[1]), .i_out_free_return(ev[2]),
		.o_in_free_addr(a_out[0]), .o_in_post_addr(a_out[1]),
		.o_out_free_addr(a_out[2]), .o_queue_port_disable(dis));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	function automatic logic [11:0] ra(input int i);
		return 12'(`QP_OFF_IN_FREE_BOT + 4 * i);
	endfunction

	function automatic logic [31:0] pv(input logic [17:0] o);
		return {BASE, o, 2'b00};
	endfunction

	task automatic rchk(input int i, input logic [31:0] e);
		logic [31:0] v;
		u_host.rd(ra(i), v);
		chk("pointer", v, e);
	endtask

	task automatic ctrl(input logic d, input logic [2:0] sz);
		u_host.wr(`QP_OFF_CTRL, {BASE, 16'h0000, d, sz});
	endtask

	task automatic pulse(input int k);
		@(posedge ref_clk);
		ev[k] <= 1'b1;
		@(posedge ref_clk);
		ev[k] <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// reset clears all five pointers and the inbound free entry address
	task automatic t_reset;
		for (int i = 0; i < 5; i++)
			rchk(i, 32'h0000_0000);
		chk("entry addr", a_out[0], 32'h0000_0000);
	endtask

	task automatic t_fields;
		ctrl(1'b0, `QP_SIZE_256);
		for (int i = 0; i < 5; i++) begin
			u_host.wr(ra(i), 32'hffff_ffff);
			rchk(i, pv(18'h3_ffff));
		end
		chk("entry addr", a_out[1], pv(18'h3_ffff));
	endtask

	// step and wrap per size code
	task automatic t_step;
		int j;
		int n;
		for (int c = 0; c < 5; c++) begin
			n = 256 << (2 * c);
			ctrl(1'b0, 3'(c));
			for (int k = 0; k < 3; k++) begin
				j = (k == 2) ? 3 : k;
				u_host.wr(ra(j), pv(18'(n - 2)));
				pulse(k);
				rchk(j, pv(18'(n - 1)));
				chk("entry addr", a_out[k], pv(18'(n - 1)));
				pulse(k);
				rchk(j, pv(18'h0_0000));
			end
		end
	endtask

	task automatic t_host;
		u_host.wr(ra(2), pv(18'h0_0123));
		u_host.wr(ra(4), pv(18'h0_0456));
		for (int k = 0; k < 3; k++)
			pulse(k);
		rchk(2, pv(18'h0_0123));
		rchk(4, pv(18'h0_0456));
	endtask

	task automatic t_dis;
		u_host.wr(ra(0), pv(18'h0_0010));
		ctrl(1'b1, `QP_SIZE_64K);
		rchk(0, 32'hffff_ffff);
		chk("disable", {31'h0000_0000, dis}, 32'h0000_0001);
		u_host.wr(ra(0), 32'h0000_0000);
		ctrl(1'b0, `QP_SIZE_64K);
		rchk(0, pv(18'h0_0010));
		rchk(5, 32'h0000_0000);
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic stop_test;
		if (n_fail == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence after a six-cycle reset
	initial begin
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		t_reset();
		t_fields();
		t_step();
		t_host();
		t_dis();
		stop_test();
	end

	// Watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		stop_test();
	end
endmodule // tb
